// ==== rtl/mfab_pkg.sv ====
// Package: register map, field layout and encodings of the flow action decoder
package mfab_pkg;
  localparam logic [11:0] MFAB_OFF_CTRL     = 12'h000;
  localparam logic [11:0] MFAB_OFF_ETYPE    = 12'h004;
  localparam logic [11:0] MFAB_OFF_NM_NCP   = 12'h008;
  localparam logic [11:0] MFAB_OFF_NM_CP    = 12'h00c;
  localparam logic [11:0] MFAB_OFF_STATUS   = 12'h010;
  localparam logic [11:0] MFAB_OFF_EGR_BASE = 12'h100;
  localparam logic [11:0] MFAB_OFF_IGR_BASE = 12'h200;
  localparam logic [31:0] MFAB_RST_ZERO     = 32'h0000_0000;
  localparam logic [31:0] MFAB_UNMAPPED     = 32'hdead_beef;
  // Control register fields
  localparam int MFAB_CTRL_IGR_BIT  = 0;
  localparam int MFAB_CTRL_TAGB_BIT = 1;
  localparam int MFAB_CTRL_HSZ_LSB  = 4;
  localparam logic [3:0] MFAB_HSZ_MAX_CODE = 4'h8;
  // Flow types
  localparam logic [1:0] MFAB_FT_BYPASS  = 2'h0;
  localparam logic [1:0] MFAB_FT_DROP    = 2'h1;
  localparam logic [1:0] MFAB_FT_PROCESS = 2'h2;
  // Destination ports
  localparam logic [1:0] MFAB_PORT_COMMON   = 2'h0;
  localparam logic [1:0] MFAB_PORT_RESERVED = 2'h1;
  localparam logic [1:0] MFAB_PORT_CTRLD    = 2'h2;
  localparam logic [1:0] MFAB_PORT_UNCTRLD  = 2'h3;
  // Tag classes
  localparam logic [1:0] MFAB_TAG_UNTAGGED = 2'h0;
  localparam logic [1:0] MFAB_TAG_TAGGED   = 2'h1;
  localparam logic [1:0] MFAB_TAG_BAD      = 2'h2;
  localparam logic [1:0] MFAB_TAG_KAY      = 2'h3;
  // Common action fields
  localparam int MFAB_A_TYPE = 0;
  localparam int MFAB_A_DEST = 2;
  localparam int MFAB_A_DROP = 4;
  // Egress action fields
  localparam int MFAB_E_PROT  = 6;
  localparam int MFAB_E_INUSE = 7;
  localparam int MFAB_E_SCI   = 8;
  localparam int MFAB_E_ES    = 9;
  localparam int MFAB_E_SCB   = 10;
  localparam int MFAB_E_TAGB  = 11;
  localparam int MFAB_E_COFF  = 13;
  localparam int MFAB_E_CPROT = 20;
  // Ingress action fields
  localparam int MFAB_I_DNR   = 6;
  localparam int MFAB_I_RPL   = 7;
  localparam int MFAB_I_INUSE = 8;
  localparam int MFAB_I_VAL   = 9;
  localparam int MFAB_I_COFF  = 11;
  // Non-matching category byte: bit0 drop, [2:1] dest, [4:3] drop method
  localparam int MFAB_NM_DROP = 0;
  localparam int MFAB_NM_DEST = 1;
  localparam int MFAB_NM_DM   = 3;
  // Frame geometry in bytes
  localparam logic [5:0] MFAB_MAC_HDR  = 6'd12;
  localparam logic [5:0] MFAB_ETH_HDR  = 6'd14;
  localparam logic [5:0] MFAB_VLAN_LEN = 6'd4;
  localparam logic [3:0] MFAB_MATCH_MAX = 4'd8;
endpackage

// ==== rtl/mfab_top.sv ====
// Per-flow action decode with VLAN tag bypass and header bypass classification
module mfab_top #(
  parameter int NUM_SA = 4,
  parameter int IDX_W  = 2
) (
  input  wire logic                 clk_i,             // Engine clock
  input  wire logic                 rst_b_i,           // Sync reset, active low
  input  wire logic [11:0]          reg_addr_i,        // Register byte address
  input  wire logic [31:0]          reg_wdata_i,       // Write data
  input  wire logic                 reg_wr_i,          // Write strobe
  input  wire logic                 reg_rd_i,          // Read strobe
  output logic      [31:0]          reg_rdata_o,       // Read data, cycle after strobe
  input  wire logic                 pkt_valid_i,       // Match result valid, one per packet
  input  wire logic                 sa_hit_i,          // Packet matched an SA flow
  input  wire logic [IDX_W-1:0]     sa_index_i,        // Matched SA index
  input  wire logic [1:0]           tag_class_i,       // Tag classifier result
  input  wire logic                 ctrl_outer_i,      // Control detect on outer addr/etype
  input  wire logic                 ctrl_inner_i,      // Control detect on inner addr/etype
  input  wire logic [15:0]          outer_ethertype_i, // Outer ethertype of packet
  input  wire logic [1:0]           src_port_i,        // Port the packet arrived from
  input  wire logic [1:0]           vlan_count_i,      // Parser tag count before SecTAG
  output logic                      act_valid_o,       // Decoded action pulse
  output logic [1:0]                act_type_o,        // Effective flow type
  output logic [1:0]                act_dest_port_o,   // Destination port code
  output logic [1:0]                act_drop_method_o, // Drop method
  output logic                      ctx_fetch_o,       // Context fetch request pulse
  output logic [IDX_W-1:0]          ctx_index_o,       // Context index to fetch
  output logic                      protect_o,         // Egress protect frame
  output logic                      assoc_in_use_flag_o, // Assoc_in_use_flag
  output logic                      include_sci_o,     // Egress include SCI
  output logic                      end_station_bit_enable_o, // Egress ES bit enable
  output logic                      scb_bit_enable_o,  // Egress SCB bit enable
  output logic                      replay_protect_o,  // Ingress replay protection
  output logic [1:0]                validate_level_o,  // Ingress validation level
  output logic [6:0]                conf_offset_o,     // Confidentiality offset
  output logic                      conf_protect_o,    // Egress confidentiality enable
  output logic [1:0]                bypass_tags_o,     // VLAN tags kept outside crypto
  output logic [5:0]                sectag_pos_o,      // SecTAG byte offset
  output logic [4:0]                hdr_bytes_o,       // Bypassed header field bytes
  output logic [3:0]                match_bytes_o,     // Field bytes used by SA lookup
  output logic                      is_control_o       // Control packet class
);
  import mfab_pkg::*;

  typedef struct packed {
    logic                   igr;
    logic                   tagb;
    logic [3:0]             hsz;
    logic [15:0]            etype;
    logic [31:0]            nm_ncp;
    logic [31:0]            nm_cp;
    logic [NUM_SA-1:0][31:0] egr;
    logic [NUM_SA-1:0][31:0] igr_act;
    logic [31:0]            rdata;
    logic                   valid;
    logic [1:0]             ftype;
    logic [1:0]             dest;
    logic [1:0]             dmeth;
    logic                   fetch;
    logic [IDX_W-1:0]       cidx;
    logic                   prot;
    logic                   inuse;
    logic                   sci;
    logic                   es;
    logic                   scb;
    logic                   rpl;
    logic [1:0]             val;
    logic [6:0]             coff;
    logic                   cprot;
    logic [1:0]             btags;
    logic [5:0]             spos;
    logic [4:0]             hbytes;
    logic [3:0]             mbytes;
    logic                   ctrl;
  } mfab_state_t;

  mfab_state_t s_q;
  mfab_state_t s_d;

  // Decode an action-array address; index valid only when hit
  function automatic logic arr_hit(input logic [11:0] a, input logic [11:0] base);
    arr_hit = (a >= base) && (a < base + 12'(4 * NUM_SA)) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic [IDX_W-1:0] arr_idx(input logic [11:0] a, input logic [11:0] base);
    logic [11:0] off;
    off = a - base;
    arr_idx = off[IDX_W+1:2];
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Combinational next state
  logic [31:0] act;
  logic [7:0]  nm;
  logic [1:0]  eff_tags;
  logic        ctrl_pkt;
  logic [3:0]  hcode;

  always_comb
  begin
    s_d      = s_q;
    act      = MFAB_RST_ZERO;
    nm       = 8'h00;
    eff_tags = 2'b00;
    ctrl_pkt = 1'b0;
    hcode    = (s_q.hsz > MFAB_HSZ_MAX_CODE) ? MFAB_HSZ_MAX_CODE : s_q.hsz;
    s_d.valid = 1'b0;
    s_d.fetch = 1'b0;

    // Register writes
    if (reg_wr_i)
    begin
      if (reg_addr_i == MFAB_OFF_CTRL)
      begin
        s_d.igr  = reg_wdata_i[MFAB_CTRL_IGR_BIT];
        s_d.tagb = reg_wdata_i[MFAB_CTRL_TAGB_BIT];
        s_d.hsz  = reg_wdata_i[MFAB_CTRL_HSZ_LSB +: 4];
      end
      if (reg_addr_i == MFAB_OFF_ETYPE)
        s_d.etype = reg_wdata_i[15:0];
      if (reg_addr_i == MFAB_OFF_NM_NCP)
        s_d.nm_ncp = reg_wdata_i;
      if (reg_addr_i == MFAB_OFF_NM_CP)
        s_d.nm_cp = reg_wdata_i;
      if (arr_hit(reg_addr_i, MFAB_OFF_EGR_BASE))
        s_d.egr[arr_idx(reg_addr_i, MFAB_OFF_EGR_BASE)] = reg_wdata_i;
      if (arr_hit(reg_addr_i, MFAB_OFF_IGR_BASE))
        s_d.igr_act[arr_idx(reg_addr_i, MFAB_OFF_IGR_BASE)] = reg_wdata_i;
    end

    // Register reads, answered in the next cycle
    s_d.rdata = MFAB_RST_ZERO;
    if (reg_rd_i)
    begin
      if (reg_addr_i == MFAB_OFF_CTRL)
        s_d.rdata = {24'h00_0000, s_q.hsz, 2'b00, s_q.tagb, s_q.igr};
      else if (reg_addr_i == MFAB_OFF_ETYPE)
        s_d.rdata = {16'h0000, s_q.etype};
      else if (reg_addr_i == MFAB_OFF_NM_NCP)
        s_d.rdata = s_q.nm_ncp;
      else if (reg_addr_i == MFAB_OFF_NM_CP)
        s_d.rdata = s_q.nm_cp;
      else if (reg_addr_i == MFAB_OFF_STATUS)
        s_d.rdata = {14'h0000, s_q.ctrl, s_q.btags, s_q.spos, s_q.cidx[1:0], s_q.fetch,
                     s_q.dmeth, s_q.dest, s_q.ftype};
      else if (arr_hit(reg_addr_i, MFAB_OFF_EGR_BASE))
        s_d.rdata = s_q.egr[arr_idx(reg_addr_i, MFAB_OFF_EGR_BASE)];
      else if (arr_hit(reg_addr_i, MFAB_OFF_IGR_BASE))
        s_d.rdata = s_q.igr_act[arr_idx(reg_addr_i, MFAB_OFF_IGR_BASE)];
      else
        s_d.rdata = MFAB_UNMAPPED;
    end

    // Per-packet decode; outputs other than the valid and fetch pulses held until the next packet
    if (pkt_valid_i)
    begin
      s_d.valid = 1'b1;
      // Header bypass field size and SecTAG position
      s_d.hbytes = {hcode, 1'b0};
      s_d.mbytes = (hcode == 4'h0) ? 4'h0 :
                   (({hcode, 1'b0} > 5'(MFAB_MATCH_MAX)) ? MFAB_MATCH_MAX : 4'({hcode, 1'b0}));
      if (hcode != 4'h0)
      begin
        ctrl_pkt = (outer_ethertype_i == s_q.etype) ? ctrl_outer_i : ctrl_inner_i;
        eff_tags = 2'b00; // Header bypass excludes any other secure format
        s_d.spos = MFAB_ETH_HDR + 6'({hcode, 1'b0});
      end
      else
      begin
        ctrl_pkt = ctrl_outer_i;
        if (s_q.tagb)
        begin
          if (s_q.igr)
            eff_tags = (vlan_count_i > 2'd2) ? 2'd2 : vlan_count_i;
          else if (sa_hit_i) // No flow, no tag count: non-match keeps standard format
          begin
            act      = s_q.egr[sa_index_i];
            eff_tags = (act[MFAB_E_TAGB +: 2] > 2'd2) ? 2'd2 : act[MFAB_E_TAGB +: 2];
          end
        end
        s_d.spos = MFAB_MAC_HDR + MFAB_VLAN_LEN * 6'(eff_tags);
      end
      s_d.btags = eff_tags;
      s_d.ctrl  = ctrl_pkt;

      s_d.prot  = 1'b0;
      s_d.inuse = 1'b0;
      s_d.sci   = 1'b0;
      s_d.es    = 1'b0;
      s_d.scb   = 1'b0;
      s_d.rpl   = 1'b0;
      s_d.val   = 2'b00;
      s_d.coff  = 7'h00;
      s_d.cprot = 1'b0;
      s_d.cidx  = sa_index_i;

      if (sa_hit_i)
      begin
        act = s_q.igr ? s_q.igr_act[sa_index_i] : s_q.egr[sa_index_i];
        s_d.ftype = act[MFAB_A_TYPE +: 2];
        s_d.dest  = act[MFAB_A_DEST +: 2];
        s_d.dmeth = act[MFAB_A_DROP +: 2];
        if (s_q.igr)
        begin
          s_d.rpl   = act[MFAB_I_RPL];
          s_d.inuse = act[MFAB_I_INUSE];
          s_d.val   = act[MFAB_I_VAL +: 2];
          s_d.coff  = act[MFAB_I_COFF +: 7];
          if (act[MFAB_I_DNR] && (src_port_i != MFAB_PORT_RESERVED))
            s_d.ftype = MFAB_FT_DROP;
        end
        else
        begin
          s_d.prot  = act[MFAB_E_PROT];
          s_d.inuse = act[MFAB_E_INUSE];
          s_d.sci   = act[MFAB_E_SCI];
          s_d.es    = act[MFAB_E_ES];
          s_d.scb   = act[MFAB_E_SCB];
          s_d.coff  = act[MFAB_E_COFF +: 7];
          s_d.cprot = act[MFAB_E_CPROT];
        end
        if (s_d.ftype == 2'h3)
          s_d.ftype = MFAB_FT_BYPASS; // Unused code treated as pass
      end
      else
      begin
        // Category: control bit above tag class, four bytes per register
        nm = ctrl_pkt ? s_q.nm_cp[8 * tag_class_i +: 8] : s_q.nm_ncp[8 * tag_class_i +: 8];
        s_d.ftype = nm[MFAB_NM_DROP] ? MFAB_FT_DROP : MFAB_FT_BYPASS;
        s_d.dest  = nm[MFAB_NM_DEST +: 2];
        s_d.dmeth = nm[MFAB_NM_DM +: 2];
      end
      // Key-agreement frames set to process pass untouched in tag bypass mode without header bypass
      if (s_q.tagb && (hcode == 4'h0) && (tag_class_i == MFAB_TAG_KAY) && (s_d.ftype == MFAB_FT_PROCESS))
        s_d.ftype = MFAB_FT_BYPASS;
      // Only processed frames need keys; bypass and drop go unmodified or per method
      s_d.fetch = sa_hit_i && (s_d.ftype == MFAB_FT_PROCESS);
    end

    if (!rst_b_i)
      s_d = '0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_i)
  begin
    s_q <= s_d;
  end

  assign reg_rdata_o              = s_q.rdata;
  assign act_valid_o              = s_q.valid;
  assign act_type_o               = s_q.ftype;
  assign act_dest_port_o          = s_q.dest;
  assign act_drop_method_o        = s_q.dmeth;
  assign ctx_fetch_o              = s_q.fetch;
  assign ctx_index_o              = s_q.cidx;
  assign protect_o                = s_q.prot;
  assign assoc_in_use_flag_o      = s_q.inuse;
  assign include_sci_o            = s_q.sci;
  assign end_station_bit_enable_o = s_q.es;
  assign scb_bit_enable_o         = s_q.scb;
  assign replay_protect_o         = s_q.rpl;
  assign validate_level_o         = s_q.val;
  assign conf_offset_o            = s_q.coff;
  assign conf_protect_o           = s_q.cprot;
  assign bypass_tags_o            = s_q.btags;
  assign sectag_pos_o             = s_q.spos;
  assign hdr_bytes_o              = s_q.hbytes;
  assign match_bytes_o            = s_q.mbytes;
  assign is_control_o             = s_q.ctrl;

  //////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_nm_no_process;
    @(posedge clk_i) disable iff (!rst_b_i)
      (pkt_valid_i && !sa_hit_i) |=> (act_type_o != MFAB_FT_PROCESS);
  endproperty
  a_nm_no_process: assert property (p_nm_no_process) else $error("Non-match got process type");

  property p_tag_limit;
    @(posedge clk_i) disable iff (!rst_b_i)
      act_valid_o |-> (bypass_tags_o <= 2'd2);
  endproperty
  a_tag_limit: assert property (p_tag_limit) else $error("Bypass tag count above two");

  property p_drop_nonres;
    @(posedge clk_i) disable iff (!rst_b_i)
      (pkt_valid_i && sa_hit_i && s_q.igr && s_q.igr_act[sa_index_i][MFAB_I_DNR]
       && src_port_i != MFAB_PORT_RESERVED) |=> (act_type_o == MFAB_FT_DROP);
  endproperty
  a_drop_nonres: assert property (p_drop_nonres) else $error("Non-reserved packet not dropped");

  property p_fetch_process;
    @(posedge clk_i) disable iff (!rst_b_i)
      ctx_fetch_o |-> (act_valid_o && act_type_o == MFAB_FT_PROCESS);
  endproperty
  a_fetch_process: assert property (p_fetch_process) else $error("Fetch without process type");

  property p_hold;
    @(posedge clk_i) disable iff (!rst_b_i)
      (!pkt_valid_i && $past(rst_b_i)) |=> ($stable(act_type_o) && $stable(act_dest_port_o));
  endproperty
  a_hold: assert property (p_hold) else $error("Action changed between packets");

  property p_hdr_pos;
    @(posedge clk_i) disable iff (!rst_b_i)
      (act_valid_o && hdr_bytes_o != 5'd0) |-> (sectag_pos_o == MFAB_ETH_HDR + 6'(hdr_bytes_o)
                                               && bypass_tags_o == 2'd0);
  endproperty
  a_hdr_pos: assert property (p_hdr_pos) else $error("SecTAG not after bypass field");

  property p_hdr_even;
    @(posedge clk_i) disable iff (!rst_b_i)
      act_valid_o |-> (!hdr_bytes_o[0] && hdr_bytes_o <= 5'd16);
  endproperty
  a_hdr_even: assert property (p_hdr_even) else $error("Header field size illegal");

  property p_match_bytes;
    @(posedge clk_i) disable iff (!rst_b_i)
      act_valid_o |-> (match_bytes_o <= MFAB_MATCH_MAX && 5'(match_bytes_o) <= hdr_bytes_o);
  endproperty
  a_match_bytes: assert property (p_match_bytes) else $error("Lookup uses too many field bytes");

  property p_read_once;
    @(posedge clk_i) disable iff (!rst_b_i)
      (!reg_rd_i) |=> (reg_rdata_o == 32'h0000_0000);
  endproperty
  a_read_once: assert property (p_read_once) else $error("Read data outside answer cycle");
endmodule

// ==== verif/mfab_pipe_model.sv ====
// Pipeline-side model: issues one match result per request
module mfab_pipe_model (
  input  wire logic        clk_i,    // Engine clock
  input  wire logic        rst_b_i,  // Sync reset, active low
  input  wire logic        send_i,   // Issue one packet at next edge
  input  wire logic [26:0] bundle_i, // Packed packet fields
  output logic             valid_o,  // Match result pulse
  output logic [26:0]      fields_o  // Packed fields
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      valid_o  <= 1'b0;
      fields_o <= 27'h0;
    end
    else
    begin
      valid_o  <= send_i;
      // Idle fields flip every cycle so a stale sample cannot pass
      fields_o <= send_i ? bundle_i : ~fields_o;
    end
  end
endmodule

// ==== verif/mfab_top_bench.sv ====
// Self-checking bench for the flow action decoder
module mfab_top_bench;
  import mfab_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk       = 1'b0;
  logic        rst_b     = 1'b0;
  logic [11:0] reg_addr  = 12'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic        send      = 1'b0;
  logic [26:0] bundle    = 27'h0;
  logic [31:0] lfsr      = 32'hff3f;
  logic [31:0] rv [12];
  logic [31:0] rmask [12];
  wire  [31:0] reg_rdata;
  wire         pv;
  wire  [26:0] pf;
  wire         act_valid;
  wire  [42:0] a_vec;
  int          checks    = 0;
  int          bad_count = 0;
  always #5 clk = ~clk;
  mfab_pipe_model pipe (.clk_i(clk), .rst_b_i(rst_b), .send_i(send), .bundle_i(bundle), .valid_o(pv), .fields_o(pf));
  mfab_top uut (
    .clk_i(clk), .rst_b_i(rst_b), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
    .pkt_valid_i(pv), .sa_hit_i(pf[0]), .sa_index_i(pf[2:1]), .tag_class_i(pf[4:3]),
    .ctrl_outer_i(pf[5]), .ctrl_inner_i(pf[6]), .outer_ethertype_i(pf[22:7]),
    .src_port_i(pf[24:23]), .vlan_count_i(pf[26:25]), .act_valid_o(act_valid),
    .act_type_o(a_vec[42:41]), .act_dest_port_o(a_vec[40:39]), .act_drop_method_o(a_vec[38:37]),
    .ctx_fetch_o(a_vec[36]), .ctx_index_o(a_vec[35:34]), .protect_o(a_vec[33]),
    .assoc_in_use_flag_o(a_vec[32]), .include_sci_o(a_vec[31]), .end_station_bit_enable_o(a_vec[30]),
    .scb_bit_enable_o(a_vec[29]), .replay_protect_o(a_vec[28]), .validate_level_o(a_vec[27:26]),
    .conf_offset_o(a_vec[25:19]), .conf_protect_o(a_vec[18]), .bypass_tags_o(a_vec[17:16]),
    .sectag_pos_o(a_vec[15:10]), .hdr_bytes_o(a_vec[9:5]), .match_bytes_o(a_vec[4:1]), .is_control_o(a_vec[0])
  );
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [11:0] raddr(input int i);
    return (i < 4) ? 12'(4 * i) : (i < 8) ? MFAB_OFF_EGR_BASE + 12'(4 * (i - 4)) : MFAB_OFF_IGR_BASE + 12'(4 * (i - 8));
  endfunction
  // Expected decode of one packet; m clears fields the bench cannot pin down
  function automatic logic [42:0] predict(input logic [26:0] b, output logic [42:0] m);
    logic [42:0] e;
    logic [31:0] w;
    logic [7:0]  nb;
    logic [3:0]  code;
    logic [4:0]  hb;
    logic [1:0]  ty;
    logic [1:0]  tags;
    logic        ig;
    logic        tm;
    logic        hdr;
    logic        ctl;
    ig   = rv[0][MFAB_CTRL_IGR_BIT];
    tm   = rv[0][MFAB_CTRL_TAGB_BIT];
    code = (rv[0][7:4] > MFAB_HSZ_MAX_CODE) ? MFAB_HSZ_MAX_CODE : rv[0][7:4];
    hdr  = code != 4'h0;
    hb   = {code, 1'b0};
    ctl  = (hdr && b[22:7] != rv[1][15:0]) ? b[6] : b[5];
    e    = '0;
    m    = '1;
    tags = 2'h0;
    if (b[0])
    begin
      w  = ig ? rv[8 + b[2:1]] : rv[4 + b[2:1]];
      ty = (w[1:0] == 2'h3) ? MFAB_FT_BYPASS : w[1:0];
      if (tm && !hdr && b[4:3] == MFAB_TAG_KAY && ty == MFAB_FT_PROCESS)
        ty = MFAB_FT_BYPASS;
      if (ig && w[MFAB_I_DNR] && b[24:23] != MFAB_PORT_RESERVED)
        ty = MFAB_FT_DROP;
      e[42:34] = {ty, w[3:2], w[5:4], ty == MFAB_FT_PROCESS, b[2:1]};
      if (ig)
        {e[32], e[28:19]} = {w[8], w[7], w[10:9], w[17:11]};
      else
      begin
        e[33:29] = {w[6], w[7], w[8], w[9], w[10]};
        e[25:18] = {w[19:13], w[20]};
        tags = (!tm || hdr) ? 2'h0 : (w[12:11] == 2'h3) ? 2'h2 : w[12:11];
      end
    end
    else
    begin
      nb = 8'((ctl ? rv[3] : rv[2]) >> (8 * b[4:3]));
      e[42:37] = {1'b0, nb[0], nb[2:1], nb[4:3]};
    end
    if (!e[36])
      m[35:34] = 2'h0;
    if (ig && tm && !hdr)
      tags = (b[26:25] == 2'h3) ? 2'h2 : b[26:25];
    e[17:0] = {tags, hdr ? MFAB_ETH_HDR + {1'b0, hb} : MFAB_MAC_HDR + {2'b0, tags, 2'b0},
               hb, (hb > 5'd8) ? 4'd8 : hb[3:0], ctl};
    return e;
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    @(negedge clk);
    chk(reg_rdata & m, e & m);
    @(negedge clk);
    chk(reg_rdata, 32'h0);
  endtask
  // Optional leading packet makes the pair back to back
  task automatic send_pkt(input logic [26:0] b, input logic dbl);
    logic [42:0] e;
    logic [42:0] m;
    e = predict(b, m);
    @(posedge clk);
    if (dbl)
    begin
      send   <= 1'b1;
      bundle <= ~b;
      @(posedge clk);
    end
    send   <= 1'b1;
    bundle <= b;
    @(posedge clk);
    send   <= 1'b0;
    @(negedge clk);
    chk(act_valid, dbl);
    @(negedge clk);
    chk({act_valid, a_vec & m}, {1'b1, e & m});
    repeat (2) @(negedge clk);
    // Fetch is a one-cycle pulse; every other field must hold
    chk({act_valid, a_vec & m}, {1'b0, e & m & ~43'h10_0000_0000});
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #200000;
    bad_count++;
    $display("MISMATCH t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    tally_and_finish();
  end
  initial
  begin
    logic [31:0] r;
    for (int i = 0; i < 12; i++)
      rmask[i] = (i == 0) ? 32'hf3 : (i == 1) ? 32'hffff : (i < 4) ? 32'h1f1f1f1f : (i < 8) ? 32'h1fffff : 32'h3ffff;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 12; i++)
      rd_chk(raddr(i), MFAB_RST_ZERO, 32'hffffffff);
    rd_chk(MFAB_OFF_STATUS, MFAB_RST_ZERO, 32'hffffffff);
    rd_chk(12'h0f0, MFAB_UNMAPPED, 32'hffffffff);
    // Unaligned write must leave the word untouched
    wr(MFAB_OFF_EGR_BASE + 12'h2, 32'hffffffff);
    rd_chk(MFAB_OFF_EGR_BASE, MFAB_RST_ZERO, 32'hffffffff);
    $display("test registers done");
    for (int k = 0; k < 8; k++)
    begin
      for (int i = 0; i < 12; i++)
      begin
        lfsr  = lfsr_next(lfsr);
        rv[i] = lfsr;
      end
      rv[0] = (k == 0) ? 32'h2 : (k == 1) ? 32'h3 : (k == 2) ? 32'h91
            : {24'h0, rv[0][8] ? rv[0][7:4] : 4'h0, 2'h0, rv[0][1:0]};
      if (k < 2)
      begin
        rv[4][1:0]   = MFAB_FT_PROCESS;
        rv[5][12:11] = 2'h3;
        rv[8][7:0]   = {rv[8][7], 1'b1, rv[8][5:2], MFAB_FT_PROCESS};
      end
      for (int i = 0; i < 12; i++)
        wr(raddr(i), rv[i]);
      for (int i = 0; i < 12; i++)
        rd_chk(raddr(i), rv[i], rmask[i]);
      for (int n = 0; n < 10; n++)
      begin
        lfsr = lfsr_next(lfsr);
        r    = lfsr;
        if (r[31])
          r[22:7] = rv[1][15:0];
        if (k < 2 && n == 0)
          r[4:0] = 5'h19;
        if (k < 2 && n == 1)
          r[2:0] = 3'h3;
        send_pkt(r[26:0], r[30]);
      end
      $display("test config %0d done", k);
    end
    tally_and_finish();
  end
endmodule
